// ### inc/lcdcfg_pkg.sv
// package: opcodes, field layouts, reset values and timing of the lcd config decoder
package lcdcfg_pkg;

    // ==========================================================
    // opcode patterns, compared against the upper bits of a byte
    // ==========================================================
    localparam logic [5:0] TEMP_SW_OP = 6'h32;
    localparam logic [4:0] COEF_A_OP = 5'h03;
    localparam logic [4:0] COEF_B_OP = 5'h04;
    localparam logic [4:0] COEF_C_OP = 5'h05;
    localparam logic [4:0] COEF_D_OP = 5'h06;
    localparam logic [3:0] PUMP_HI_OP = 4'h4;
    localparam logic [3:0] PUMP_LO_OP = 4'h5;
    localparam logic [6:0] DISPLAY_OP = 7'h1C;
    localparam logic [4:0] RATIO_OP = 5'h00;
    localparam logic [5:0] BIAS_OP = 6'h31;
    localparam logic [7:0] INIT_BYTE = 8'h3A;

    // ==========================================================
    // field positions inside a command byte
    // ==========================================================
    localparam int OP6_LSB = 2;
    localparam int OP5_LSB = 3;
    localparam int OP4_LSB = 4;
    localparam int OP7_LSB = 1;
    localparam int COMP_BIT = 1;
    localparam int SENSOR_BIT = 0;
    localparam int DISPLAY_BIT = 0;
    localparam int COEF_W = 3;
    localparam int NIBBLE_W = 4;
    localparam int RATIO_W = 3;
    localparam int BIAS_W = 2;

    // ==========================================================
    // reset values
    // ==========================================================
    localparam logic RST_COMP = 1'h1;
    localparam logic RST_SENSOR = 1'h1;
    localparam logic RST_DISPLAY = 1'h0;
    localparam logic [COEF_W-1:0] RST_COEF = 3'h0;
    localparam logic [NIBBLE_W-1:0] RST_NIBBLE = 4'h0;
    localparam logic [RATIO_W-1:0] RST_RATIO = 3'h0;
    localparam logic [BIAS_W-1:0] RST_BIAS = 2'h0;

    // ==========================================================
    // multiplex ratio codes and the drive they select
    // ==========================================================
    localparam logic [RATIO_W-1:0] RATIO_8_A = 3'h0;
    localparam logic [RATIO_W-1:0] RATIO_STATIC = 3'h1;
    localparam logic [RATIO_W-1:0] RATIO_2 = 3'h2;
    localparam logic [RATIO_W-1:0] RATIO_8_B = 3'h3;
    localparam logic [RATIO_W-1:0] RATIO_4 = 3'h4;
    localparam logic [RATIO_W-1:0] RATIO_8_C = 3'h5;
    localparam logic [RATIO_W-1:0] RATIO_6 = 3'h6;
    localparam logic [RATIO_W-1:0] RATIO_8_D = 3'h7;
    localparam logic [3:0] BP_COUNT_8 = 4'h8;
    localparam logic [3:0] BP_COUNT_6 = 4'h6;
    localparam logic [3:0] BP_COUNT_4 = 4'h4;
    localparam logic [3:0] BP_COUNT_2 = 4'h2;
    localparam logic [3:0] BP_COUNT_1 = 4'h1;
    localparam logic [5:0] SEG_COUNT_44 = 6'h2C;
    localparam logic [5:0] SEG_COUNT_46 = 6'h2E;
    localparam logic [7:0] BP_MASK_8 = 8'hFF;
    localparam logic [7:0] BP_MASK_6 = 8'h3F;
    localparam logic [7:0] BP_MASK_4 = 8'h0F;
    localparam logic [7:0] BP_MASK_2 = 8'h03;
    localparam logic [7:0] BP_MASK_1 = 8'h01;
    localparam logic [7:0] BP_MASK_NONE = 8'h00;

    // bias field codes
    localparam logic [BIAS_W-1:0] BIAS_Q_A = 2'h0;
    localparam logic [BIAS_W-1:0] BIAS_Q_B = 2'h1;
    localparam logic [BIAS_W-1:0] BIAS_H = 2'h2;
    localparam logic [BIAS_W-1:0] BIAS_T = 2'h3;

    typedef enum logic [2:0] {
        MUX_STATIC = 3'h0,
        MUX_1_2 = 3'h1,
        MUX_1_4 = 3'h2,
        MUX_1_6 = 3'h3,
        MUX_1_8 = 3'h4
    } lcdcfg_mux_e;

    typedef enum logic [1:0] {
        BIAS_NONE = 2'h0,
        BIAS_HALF = 2'h1,
        BIAS_THIRD = 2'h2,
        BIAS_QUARTER = 2'h3
    } lcdcfg_bias_e;

    // ==========================================================
    // timing of the initialize command
    // ==========================================================
    localparam int CLK_PERIOD_NS = 8;
    localparam int INIT_TIME_NS = 100;
    localparam int INIT_CYCLES_RAW = INIT_TIME_NS / CLK_PERIOD_NS;
    localparam int INIT_CYCLES = (INIT_CYCLES_RAW < 1) ? 1 : INIT_CYCLES_RAW;
    localparam int INIT_CNT_W = 4;
    localparam logic [INIT_CNT_W-1:0] INIT_LOAD = INIT_CYCLES[INIT_CNT_W-1:0];
    localparam logic [INIT_CNT_W-1:0] INIT_ZERO = 4'h0;
    localparam logic [INIT_CNT_W-1:0] INIT_STEP = 4'h1;

endpackage

// ### verilog/lcdcfg_field.sv
// one setting register with load, initialize and synchronous reset
`timescale 1ns/1ps

module lcdcfg_field #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // update controls
    input wire logic clear,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    // stored value and the value it takes at the next edge
    output logic [WIDTH-1:0] q,
    output logic [WIDTH-1:0] next_q
);

    // initialize wins over a load; nothing else touches the value
    always_comb begin
        next_q = q;
        if (clear) begin
            next_q = RESET_VALUE;
        end else if (load) begin
            next_q = load_value;
        end
    end

    // storage only
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            q <= RESET_VALUE;
        end else begin
            q <= next_q;
        end
    end

endmodule

// ### verilog/lcdcfg_decoder.sv
// configuration command decoder of the multiplexed lcd driver
`timescale 1ns/1ps

// Summary of operation
// - upper six bits 110010: bit1 compensation switch, bit0 sensor switch
// - comp_enable 0 blocks compensation, 1 allows it; resets to 1
// - sensor_enable 0 stops measurement and readout, 1 enables; resets to 1
// - upper five 00011/00100/00101 load low three bits into region A/B/C
// - upper five 00110 loads region D; all four coefficients reset to 000
// - upper nibble 0100 loads lower nibble into pump level high half
// - upper nibble 0101 loads lower nibble into pump level low half
// - assembled eight-bit level is the pump target; both halves reset 0000
// - upper seven bits 0011100 is display on/off, bit0 is display_on
// - display_on 0 (reset) grounds all backplanes and segments; 1 drives normally
// - upper five bits 00000 is the ratio command, low three bits the code
// - codes 000, 011, 101, 111 select 1:8, eight backplanes, 44 segments
// - code 110 selects 1:6, six backplanes, 46 segments
// - code 100 selects 1:4, four backplanes, 44 segments
// - code 010 selects 1:2, two backplanes, 44 segments
// - code 001 selects static, one backplane, 44 segments
// - upper six bits 110001 is the bias command, low two bits the field
// - 00/01 quarter, 11 third, 10 half bias; no bias in static drive
// - byte 00111010 restores every setting within 100 ns
// - commands only with register select 0; select 1 is ram data
module lcdcfg_decoder (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // byte strobe from the serial control interface
    input wire logic cmd_valid,
    input wire logic cmd_rs,
    input wire logic [7:0] cmd_byte,
    // temperature control
    output logic comp_enable,
    output logic sensor_enable,
    output logic [2:0] coef_region_a,
    output logic [2:0] coef_region_b,
    output logic [2:0] coef_region_c,
    output logic [2:0] coef_region_d,
    // charge pump target
    output logic [7:0] pump_target_level,
    // display drive configuration
    output logic display_on,
    output logic [2:0] drive_ratio_code,
    output logic [1:0] bias_code,
    output lcdcfg_pkg::lcdcfg_mux_e drive_mode,
    output lcdcfg_pkg::lcdcfg_bias_e bias_level,
    output logic [3:0] backplane_count,
    output logic [5:0] segment_count,
    output logic [7:0] backplane_enable,
    output logic outputs_grounded,
    // command status
    output logic init_busy,
    output logic cmd_accepted,
    output logic cmd_unknown,
    output logic ram_data_seen
);

    // ==========================================================
    // opcode matching
    // ==========================================================
    logic is_cmd;
    logic hit_temp;
    logic hit_coef_a;
    logic hit_coef_b;
    logic hit_coef_c;
    logic hit_coef_d;
    logic hit_pump_hi;
    logic hit_pump_lo;
    logic hit_display;
    logic hit_ratio;
    logic hit_bias;
    logic hit_init;
    logic hit_any;

    // a byte flagged as ram data never reaches the opcode compare
    assign is_cmd = cmd_valid && !cmd_rs;

    // each compare looks only at the fixed bits of its opcode
    always_comb begin
        hit_temp = is_cmd && (cmd_byte[7:lcdcfg_pkg::OP6_LSB] == lcdcfg_pkg::TEMP_SW_OP);
        hit_coef_a = is_cmd && (cmd_byte[7:lcdcfg_pkg::OP5_LSB] == lcdcfg_pkg::COEF_A_OP);
        hit_coef_b = is_cmd && (cmd_byte[7:lcdcfg_pkg::OP5_LSB] == lcdcfg_pkg::COEF_B_OP);
        hit_coef_c = is_cmd && (cmd_byte[7:lcdcfg_pkg::OP5_LSB] == lcdcfg_pkg::COEF_C_OP);
        hit_coef_d = is_cmd && (cmd_byte[7:lcdcfg_pkg::OP5_LSB] == lcdcfg_pkg::COEF_D_OP);
        hit_pump_hi = is_cmd && cmd_byte[7:lcdcfg_pkg::OP4_LSB] == lcdcfg_pkg::PUMP_HI_OP;
        hit_pump_lo = is_cmd && cmd_byte[7:lcdcfg_pkg::OP4_LSB] == lcdcfg_pkg::PUMP_LO_OP;
        hit_display = is_cmd && cmd_byte[7:lcdcfg_pkg::OP7_LSB] == lcdcfg_pkg::DISPLAY_OP;
        hit_ratio = is_cmd && (cmd_byte[7:lcdcfg_pkg::OP5_LSB] == lcdcfg_pkg::RATIO_OP);
        hit_bias = is_cmd && (cmd_byte[7:lcdcfg_pkg::OP6_LSB] == lcdcfg_pkg::BIAS_OP);
        hit_init = is_cmd && (cmd_byte == lcdcfg_pkg::INIT_BYTE);
        hit_any = hit_temp || hit_coef_a || hit_coef_b || hit_coef_c || hit_coef_d
            || hit_pump_hi || hit_pump_lo || hit_display || hit_ratio || hit_bias
            || hit_init;
    end

    // ==========================================================
    // setting registers
    // ==========================================================
    logic [3:0] pump_hi;
    logic [3:0] pump_lo;
    logic display_flag;
    logic [2:0] ratio_code;
    logic [2:0] next_ratio_code;
    logic [1:0] bias_field;
    logic [1:0] next_bias_field;
    logic next_display_flag;

    // temperature switches, both from one command byte
    lcdcfg_field #(.WIDTH(1), .RESET_VALUE(lcdcfg_pkg::RST_COMP)) u_comp (
        .clk_sys(clk_sys), .reset(reset), .clear(hit_init), .load(hit_temp),
        .load_value(cmd_byte[lcdcfg_pkg::COMP_BIT]), .q(comp_enable), .next_q()
    );
    lcdcfg_field #(.WIDTH(1), .RESET_VALUE(lcdcfg_pkg::RST_SENSOR)) u_sensor (
        .clk_sys(clk_sys), .reset(reset), .clear(hit_init), .load(hit_temp),
        .load_value(cmd_byte[lcdcfg_pkg::SENSOR_BIT]), .q(sensor_enable), .next_q()
    );

    // per-region compensation coefficients
    lcdcfg_field #(.WIDTH(3), .RESET_VALUE(lcdcfg_pkg::RST_COEF)) u_coef_a (
        .clk_sys(clk_sys), .reset(reset), .clear(hit_init), .load(hit_coef_a),
        .load_value(cmd_byte[lcdcfg_pkg::COEF_W-1:0]), .q(coef_region_a), .next_q()
    );
    lcdcfg_field #(.WIDTH(3), .RESET_VALUE(lcdcfg_pkg::RST_COEF)) u_coef_b (
        .clk_sys(clk_sys), .reset(reset), .clear(hit_init), .load(hit_coef_b),
        .load_value(cmd_byte[lcdcfg_pkg::COEF_W-1:0]), .q(coef_region_b), .next_q()
    );
    lcdcfg_field #(.WIDTH(3), .RESET_VALUE(lcdcfg_pkg::RST_COEF)) u_coef_c (
        .clk_sys(clk_sys), .reset(reset), .clear(hit_init), .load(hit_coef_c),
        .load_value(cmd_byte[lcdcfg_pkg::COEF_W-1:0]), .q(coef_region_c), .next_q()
    );
    lcdcfg_field #(.WIDTH(3), .RESET_VALUE(lcdcfg_pkg::RST_COEF)) u_coef_d (
        .clk_sys(clk_sys), .reset(reset), .clear(hit_init), .load(hit_coef_d),
        .load_value(cmd_byte[lcdcfg_pkg::COEF_W-1:0]), .q(coef_region_d), .next_q()
    );

    // pump target halves are separate so one write never disturbs the other
    lcdcfg_field #(.WIDTH(4), .RESET_VALUE(lcdcfg_pkg::RST_NIBBLE)) u_pump_hi (
        .clk_sys(clk_sys), .reset(reset), .clear(hit_init), .load(hit_pump_hi),
        .load_value(cmd_byte[lcdcfg_pkg::NIBBLE_W-1:0]), .q(pump_hi), .next_q()
    );
    lcdcfg_field #(.WIDTH(4), .RESET_VALUE(lcdcfg_pkg::RST_NIBBLE)) u_pump_lo (
        .clk_sys(clk_sys), .reset(reset), .clear(hit_init), .load(hit_pump_lo),
        .load_value(cmd_byte[lcdcfg_pkg::NIBBLE_W-1:0]), .q(pump_lo), .next_q()
    );
    assign pump_target_level = {pump_hi, pump_lo};

    // display switch, ratio and bias; their next values feed the decode below
    lcdcfg_field #(.WIDTH(1), .RESET_VALUE(lcdcfg_pkg::RST_DISPLAY)) u_display (
        .clk_sys(clk_sys), .reset(reset), .clear(hit_init), .load(hit_display),
        .load_value(cmd_byte[lcdcfg_pkg::DISPLAY_BIT]), .q(display_flag),
        .next_q(next_display_flag)
    );
    lcdcfg_field #(.WIDTH(3), .RESET_VALUE(lcdcfg_pkg::RST_RATIO)) u_ratio (
        .clk_sys(clk_sys), .reset(reset), .clear(hit_init), .load(hit_ratio),
        .load_value(cmd_byte[lcdcfg_pkg::RATIO_W-1:0]), .q(ratio_code),
        .next_q(next_ratio_code)
    );
    lcdcfg_field #(.WIDTH(2), .RESET_VALUE(lcdcfg_pkg::RST_BIAS)) u_bias (
        .clk_sys(clk_sys), .reset(reset), .clear(hit_init), .load(hit_bias),
        .load_value(cmd_byte[lcdcfg_pkg::BIAS_W-1:0]), .q(bias_field),
        .next_q(next_bias_field)
    );
    assign display_on = display_flag;
    assign drive_ratio_code = ratio_code;
    assign bias_code = bias_field;

    // ==========================================================
    // drive decode
    // ==========================================================
    lcdcfg_pkg::lcdcfg_mux_e next_drive_mode;
    lcdcfg_pkg::lcdcfg_bias_e next_bias_level;
    logic [3:0] next_backplane_count;
    logic [5:0] next_segment_count;
    logic [7:0] next_bp_mask;
    logic [7:0] next_backplane_enable;
    logic next_outputs_grounded;

    // decoded from next values so they change on the same edge as the code
    always_comb begin
        next_drive_mode = lcdcfg_pkg::MUX_1_8;
        next_backplane_count = lcdcfg_pkg::BP_COUNT_8;
        next_segment_count = lcdcfg_pkg::SEG_COUNT_44;
        next_bp_mask = lcdcfg_pkg::BP_MASK_8;
        unique case (next_ratio_code)
            lcdcfg_pkg::RATIO_8_A, lcdcfg_pkg::RATIO_8_B,
            lcdcfg_pkg::RATIO_8_C, lcdcfg_pkg::RATIO_8_D: begin
                next_drive_mode = lcdcfg_pkg::MUX_1_8;
                next_backplane_count = lcdcfg_pkg::BP_COUNT_8;
                next_segment_count = lcdcfg_pkg::SEG_COUNT_44;
                next_bp_mask = lcdcfg_pkg::BP_MASK_8;
            end
            lcdcfg_pkg::RATIO_6: begin
                next_drive_mode = lcdcfg_pkg::MUX_1_6;
                next_backplane_count = lcdcfg_pkg::BP_COUNT_6;
                next_segment_count = lcdcfg_pkg::SEG_COUNT_46;
                next_bp_mask = lcdcfg_pkg::BP_MASK_6;
            end
            lcdcfg_pkg::RATIO_4: begin
                next_drive_mode = lcdcfg_pkg::MUX_1_4;
                next_backplane_count = lcdcfg_pkg::BP_COUNT_4;
                next_segment_count = lcdcfg_pkg::SEG_COUNT_44;
                next_bp_mask = lcdcfg_pkg::BP_MASK_4;
            end
            lcdcfg_pkg::RATIO_2: begin
                next_drive_mode = lcdcfg_pkg::MUX_1_2;
                next_backplane_count = lcdcfg_pkg::BP_COUNT_2;
                next_segment_count = lcdcfg_pkg::SEG_COUNT_44;
                next_bp_mask = lcdcfg_pkg::BP_MASK_2;
            end
            lcdcfg_pkg::RATIO_STATIC: begin
                next_drive_mode = lcdcfg_pkg::MUX_STATIC;
                next_backplane_count = lcdcfg_pkg::BP_COUNT_1;
                next_segment_count = lcdcfg_pkg::SEG_COUNT_44;
                next_bp_mask = lcdcfg_pkg::BP_MASK_1;
            end
        endcase
    end

    // static drive has no intermediate levels, so the bias field is ignored there
    always_comb begin
        next_bias_level = lcdcfg_pkg::BIAS_QUARTER;
        unique case (next_bias_field)
            lcdcfg_pkg::BIAS_Q_A, lcdcfg_pkg::BIAS_Q_B: begin
                next_bias_level = lcdcfg_pkg::BIAS_QUARTER;
            end
            lcdcfg_pkg::BIAS_T: begin
                next_bias_level = lcdcfg_pkg::BIAS_THIRD;
            end
            lcdcfg_pkg::BIAS_H: begin
                next_bias_level = lcdcfg_pkg::BIAS_HALF;
            end
        endcase
        if (next_ratio_code == lcdcfg_pkg::RATIO_STATIC) begin
            next_bias_level = lcdcfg_pkg::BIAS_NONE;
        end
    end

    // blanking: every backplane released and all outputs tied to ground
    always_comb begin
        next_outputs_grounded = !next_display_flag;
        if (next_display_flag) begin
            next_backplane_enable = next_bp_mask;
        end else begin
            next_backplane_enable = lcdcfg_pkg::BP_MASK_NONE;
        end
    end

    // registered copies keep every decoded output straight from a flop
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            drive_mode <= lcdcfg_pkg::MUX_1_8;
            bias_level <= lcdcfg_pkg::BIAS_QUARTER;
            backplane_count <= lcdcfg_pkg::BP_COUNT_8;
            segment_count <= lcdcfg_pkg::SEG_COUNT_44;
            backplane_enable <= lcdcfg_pkg::BP_MASK_NONE;
            outputs_grounded <= 1'h1;
        end else begin
            drive_mode <= next_drive_mode;
            bias_level <= next_bias_level;
            backplane_count <= next_backplane_count;
            segment_count <= next_segment_count;
            backplane_enable <= next_backplane_enable;
            outputs_grounded <= next_outputs_grounded;
        end
    end

    // ==========================================================
    // initialize window and command status
    // ==========================================================
    logic [lcdcfg_pkg::INIT_CNT_W-1:0] init_cnt;
    logic [lcdcfg_pkg::INIT_CNT_W-1:0] next_init_cnt;
    logic next_init_busy;
    logic next_cmd_accepted;
    logic next_cmd_unknown;
    logic next_ram_data_seen;

    // settings are already restored one edge after the byte; busy only
    // reports the window, it never blocks the following commands
    always_comb begin
        next_init_cnt = init_cnt;
        if (hit_init) begin
            next_init_cnt = lcdcfg_pkg::INIT_LOAD;
        end else if (init_cnt != lcdcfg_pkg::INIT_ZERO) begin
            next_init_cnt = init_cnt - lcdcfg_pkg::INIT_STEP;
        end
        next_init_busy = (next_init_cnt != lcdcfg_pkg::INIT_ZERO);
        next_cmd_accepted = hit_any;
        next_cmd_unknown = is_cmd && !hit_any;
        next_ram_data_seen = cmd_valid && cmd_rs;
    end

    // status flops
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            init_cnt <= lcdcfg_pkg::INIT_ZERO;
            init_busy <= 1'h0;
            cmd_accepted <= 1'h0;
            cmd_unknown <= 1'h0;
            ram_data_seen <= 1'h0;
        end else begin
            init_cnt <= next_init_cnt;
            init_busy <= next_init_busy;
            cmd_accepted <= next_cmd_accepted;
            cmd_unknown <= next_cmd_unknown;
            ram_data_seen <= next_ram_data_seen;
        end
    end

endmodule

// ### sim/lcdcfg_asserts.sv
// checker: timing relations on the lcd config decoder ports
`timescale 1ns/1ps

module lcdcfg_asserts (
    // clock, reset and byte input
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic cmd_valid,
    input wire logic cmd_rs,
    input wire logic [7:0] cmd_byte,
    // watched outputs
    input wire logic comp_enable,
    input wire logic sensor_enable,
    input wire logic [7:0] pump_target_level,
    input wire logic display_on,
    input wire logic [2:0] drive_ratio_code,
    input wire logic [1:0] bias_code,
    input wire lcdcfg_pkg::lcdcfg_bias_e bias_level,
    input wire logic [3:0] backplane_count,
    input wire logic [7:0] backplane_enable,
    input wire logic outputs_grounded,
    input wire logic cmd_unknown,
    input wire logic ram_data_seen
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // a command byte, as opposed to ram data
    logic cmd;
    assign cmd = cmd_valid && !cmd_rs;
    // ==========================================================
    // properties
    // ==========================================================
    AST_TEMP_SW: assert property (
        cmd && cmd_byte[7:2] == 6'h32 |=> {comp_enable, sensor_enable} == $past(cmd_byte[1:0]))
        else $error("temperature switches not loaded");
    AST_PUMP_HI: assert property (
        cmd && cmd_byte[7:4] == 4'h4 |=> pump_target_level[7:4] == $past(cmd_byte[3:0])
        && $stable(pump_target_level[3:0])) else $error("pump high half wrong");
    AST_PUMP_LO: assert property (
        cmd && cmd_byte[7:4] == 4'h5 |=> pump_target_level[3:0] == $past(cmd_byte[3:0])
        && $stable(pump_target_level[7:4])) else $error("pump low half wrong");
    AST_DISPLAY: assert property (
        cmd && cmd_byte[7:1] == 7'h1C |=> display_on == $past(cmd_byte[0]))
        else $error("display flag not loaded");
    AST_GROUND: assert property (
        !display_on |-> backplane_enable == 8'h00 && outputs_grounded)
        else $error("outputs driven while display off");
    AST_STATIC: assert property (
        drive_ratio_code == 3'h1 |-> backplane_count == 4'h1
        && bias_level == lcdcfg_pkg::BIAS_NONE) else $error("static drive wrong");
    AST_INIT: assert property (
        cmd && cmd_byte == 8'h3A |=> comp_enable && sensor_enable && !display_on
        && pump_target_level == 8'h00 && drive_ratio_code == 3'h0 && bias_code == 2'h0)
        else $error("initialize left a setting");
    AST_RAM: assert property (
        cmd_valid && cmd_rs |=> ram_data_seen && $stable(display_on)
        && $stable(pump_target_level)) else $error("ram byte decoded");
    AST_UNKNOWN: assert property (
        cmd_unknown |-> $stable(pump_target_level) && $stable(drive_ratio_code)
        && $stable(bias_code)) else $error("unknown byte changed state");
endmodule

bind lcdcfg_decoder lcdcfg_asserts i_lcdcfg_asserts (.clk_sys(clk_sys), .reset(reset),
    .cmd_valid(cmd_valid), .cmd_rs(cmd_rs), .cmd_byte(cmd_byte),
    .comp_enable(comp_enable), .sensor_enable(sensor_enable),
    .pump_target_level(pump_target_level), .display_on(display_on),
    .drive_ratio_code(drive_ratio_code), .bias_code(bias_code), .bias_level(bias_level),
    .backplane_count(backplane_count), .backplane_enable(backplane_enable),
    .outputs_grounded(outputs_grounded), .cmd_unknown(cmd_unknown),
    .ram_data_seen(ram_data_seen));

// ### sim/lcdcfg_host.sv
// host model: hands command and ram bytes to the decoder
`timescale 1ns/1ps

module lcdcfg_host (
    // clock
    input wire logic clk_sys,
    // byte strobe towards the decoder
    output logic cmd_valid,
    output logic cmd_rs,
    output logic [7:0] cmd_byte
);
    // idle from time zero
    initial begin
        cmd_valid = 1'h0;
        cmd_rs = 1'h0;
        cmd_byte = 8'h00;
    end
    // one byte, strobe high one cycle; returns with the answer settled
    task automatic send(input logic rs, input logic [7:0] b);
        @(posedge clk_sys);
        cmd_valid <= 1'h1;
        cmd_rs <= rs;
        cmd_byte <= b;
        @(posedge clk_sys);
        cmd_valid <= 1'h0;
        cmd_rs <= ~rs;
        cmd_byte <= ~b; // idle lines never keep the last byte
        #1;
    endtask
endmodule

// ### sim/lcdcfg_decoder_tb_top.sv
// testbench top for the lcd config decoder
`timescale 1ns/1ps

module lcdcfg_decoder_tb_top;
    logic clk_sys, reset, cmd_valid, cmd_rs;
    logic [7:0] cmd_byte, pump_target_level, backplane_enable;
    logic comp_enable, sensor_enable, display_on, outputs_grounded;
    logic init_busy, cmd_accepted, cmd_unknown, ram_data_seen;
    logic [2:0] coef_region_a, coef_region_b, coef_region_c, coef_region_d, drive_ratio_code;
    logic [1:0] bias_code;
    logic [3:0] backplane_count;
    logic [5:0] segment_count;
    lcdcfg_pkg::lcdcfg_mux_e drive_mode;
    lcdcfg_pkg::lcdcfg_bias_e bias_level;
    int n_errors = 0, compares = 0;
    // expected backplanes per ratio code, and bias per field
    logic [7:0] bp_exp [8] = '{8'h08, 8'h01, 8'h02, 8'h08, 8'h04, 8'h08, 8'h06, 8'h08};
    logic [1:0] bias_exp [4] = '{2'h3, 2'h3, 2'h1, 2'h2};
    lcdcfg_host i_lcdcfg_host (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_rs(cmd_rs),
        .cmd_byte(cmd_byte));
    lcdcfg_decoder i_lcdcfg_decoder (.clk_sys(clk_sys), .reset(reset), .cmd_valid(cmd_valid),
        .cmd_rs(cmd_rs), .cmd_byte(cmd_byte), .comp_enable(comp_enable),
        .sensor_enable(sensor_enable), .coef_region_a(coef_region_a),
        .coef_region_b(coef_region_b), .coef_region_c(coef_region_c),
        .coef_region_d(coef_region_d), .pump_target_level(pump_target_level),
        .display_on(display_on), .drive_ratio_code(drive_ratio_code), .bias_code(bias_code),
        .drive_mode(drive_mode), .bias_level(bias_level), .backplane_count(backplane_count),
        .segment_count(segment_count), .backplane_enable(backplane_enable),
        .outputs_grounded(outputs_grounded), .init_busy(init_busy),
        .cmd_accepted(cmd_accepted), .cmd_unknown(cmd_unknown), .ram_data_seen(ram_data_seen));
    // ==========================================================
    // shared tasks
    // ==========================================================
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("mismatches %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic tx(input logic [7:0] b);
        i_lcdcfg_host.send(1'h0, b);
    endtask
    // ==========================================================
    // scenarios
    // ==========================================================
    task automatic t_defaults;
        check("comp", 8'(comp_enable), 8'h01);
        check("sensor", 8'(sensor_enable), 8'h01);
        check("coef", 8'({coef_region_a, coef_region_b}), 8'h00);
        check("coef", 8'({coef_region_c, coef_region_d}), 8'h00);
        check("pump", pump_target_level, 8'h00);
        check("bp_en", backplane_enable, 8'h00);
        check("bp", 8'(backplane_count), 8'h08);
        check("mode", 8'(drive_mode), 8'h04);
        check("bias", 8'(bias_level), 8'h03);
    endtask
    task automatic t_config;
        tx(8'hC9);
        check("temp", 8'({comp_enable, sensor_enable}), 8'h01);
        tx(8'hCA);
        check("temp", 8'({comp_enable, sensor_enable}), 8'h02);
        tx(8'h1F);
        tx(8'h26);
        tx(8'h2D);
        tx(8'h34);
        check("coef", 8'({coef_region_a, coef_region_b}), 8'h3E);
        check("coef", 8'({coef_region_c, coef_region_d}), 8'h2C);
        tx(8'h4A);
        tx(8'h53);
        check("pump", pump_target_level, 8'hA3);
        tx(8'h41);
        check("pump", pump_target_level, 8'h13);
    endtask
    task automatic t_modes;
        for (int m = 7; m >= 0; m--) begin
            tx(8'(m));
            check("bp", 8'(backplane_count), bp_exp[m]);
            check("seg", 8'(segment_count), (m == 6) ? 8'h2E : 8'h2C);
        end
        for (int b = 0; b < 4; b++) begin
            tx(8'hC4 | 8'(b));
            check("bias", 8'(bias_level), 8'(bias_exp[b]));
        end
        tx(8'h01);
        check("bias", 8'(bias_level), 8'h00);
        check("mode", 8'(drive_mode), 8'h00);
        tx(8'h00);
    endtask
    task automatic t_display;
        // blinking from the host side, then bytes that must not act
        repeat (2) begin
            tx(8'h39);
            check("bp_en", backplane_enable, 8'hFF);
            tx(8'h38);
            check("gnd", 8'(outputs_grounded), 8'h01);
        end
        tx(8'h39);
        i_lcdcfg_host.send(1'h1, 8'h38);
        check("ram", 8'({display_on, ram_data_seen}), 8'h03);
        tx(8'h80);
        check("unk", 8'({display_on, cmd_unknown}), 8'h03);
        tx(8'h3A);
        check("busy", 8'(init_busy), 8'h01);
        t_defaults();
        tx(8'h39);
        check("acc", 8'({display_on, cmd_accepted}), 8'h03);
        repeat (9) @(posedge clk_sys);
        #1 check("busy", 8'(init_busy), 8'h01);
        @(posedge clk_sys) #1 check("busy", 8'(init_busy), 8'h00);
    endtask
    // clock at 125 MHz
    initial begin
        clk_sys = 1'h0;
        forever #4 clk_sys = ~clk_sys;
    end
    // watchdog well beyond the roughly 80 cycles of the run
    initial begin
        #20000;
        n_errors++;
        complete_run();
    end
    // reset, then the scenarios in turn
    initial begin
        reset = 1'h1;
        repeat (4) @(posedge clk_sys);
        reset <= 1'h0;
        #1;
        t_defaults();
        t_config();
        t_modes();
        t_display();
        complete_run();
    end
endmodule
